// [rie_exec.sv]
// Execution unit for return-from-interrupt and byte rotate instructions
`timescale 1ns/1ps
module rie_exec
  import rie_pkg::*;
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Instruction issue
  input wire logic issue_i,
  input wire rie_op_t op_i,
  input wire logic [ADDR_W-1:0] addr_i,
  // Core state in
  input wire logic [DATA_W-1:0] mem_rdata_i,
  input wire logic [DATA_W-1:0] acc_i,
  input wire logic carry_i,
  input wire logic [PC_W-1:0] stack_top_i,
  input wire logic irq_pending_i,
  // Memory write-back
  output logic mem_we_o,
  output logic [ADDR_W-1:0] mem_addr_o,
  output logic [DATA_W-1:0] mem_wdata_o,
  // Accumulator and carry update
  output logic acc_we_o,
  output logic [DATA_W-1:0] acc_o,
  output logic carry_we_o,
  output logic carry_o,
  // Program flow
  output logic pc_load_o,
  output logic [PC_W-1:0] pc_o,
  output logic stack_pop_o,
  output logic mie_set_o,
  output logic irq_take_o
);

  // ------------------------------------------------------------
  // Operation decode
  // ------------------------------------------------------------
  logic [DATA_W-1:0] rot_result;
  logic rot_carry;
  logic is_right;
  logic is_via_carry;
  logic is_return;
  logic to_acc;

  always_comb
  begin
    is_right = (op_i == RIE_OP_ROT_RIGHT) ||
               (op_i == RIE_OP_ROT_RIGHT_ACC);
    is_via_carry = (op_i == RIE_OP_ROT_LEFT_CARRY) ||
                   (op_i == RIE_OP_ROT_LEFT_CARRY_ACC);
    is_return = issue_i && (op_i == RIE_OP_RETURN);
    to_acc = (op_i == RIE_OP_ROT_LEFT_ACC) ||
             (op_i == RIE_OP_ROT_LEFT_CARRY_ACC) ||
             (op_i == RIE_OP_ROT_RIGHT_ACC);
  end

  rie_rotator i_rie_rotator (
    .data_i(mem_rdata_i),
    .carry_i(carry_i),
    .right_i(is_right),
    .via_carry_i(is_via_carry),
    .result_o(rot_result),
    .carry_o(rot_carry)
  );

  // ------------------------------------------------------------
  // Result registers
  // ------------------------------------------------------------
  logic next_mem_we;
  logic [ADDR_W-1:0] next_mem_addr;
  logic [DATA_W-1:0] next_mem_wdata;
  logic next_acc_we;
  logic [DATA_W-1:0] next_acc;
  logic next_carry_we;
  logic next_carry;
  logic next_pc_load;
  logic [PC_W-1:0] next_pc;
  logic next_pop;
  logic next_mie;
  logic next_irq_take;

  always_comb
  begin
    next_mem_we = 1'b0;
    next_mem_addr = mem_addr_o;
    next_mem_wdata = mem_wdata_o;
    next_acc_we = 1'b0;
    next_acc = acc_o;
    next_carry_we = 1'b0;
    next_carry = carry_o;
    next_pc_load = 1'b0;
    next_pc = pc_o;
    next_pop = 1'b0;
    next_mie = 1'b0;
    next_irq_take = 1'b0;
    if (is_return)
    begin
      // The carry flag is never touched on return
      next_pc_load = 1'b1;
      next_pc = stack_top_i;
      next_pop = 1'b1;
      next_mie = MIE_SET;
      // Same cycle as the PC load, so the core vectors before fetching
      // anything at the restored address
      next_irq_take = irq_pending_i;
    end
    else if (issue_i)
    begin
      if (to_acc)
      begin
        next_acc_we = 1'b1;
        next_acc = rot_result;
      end
      else
      begin
        next_mem_we = 1'b1;
        next_mem_addr = addr_i;
        next_mem_wdata = rot_result;
      end
      // Only the through-carry forms touch the carry flag
      next_carry_we = is_via_carry;
      next_carry = rot_carry;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_n_i)
    begin
      mem_we_o <= 1'b0;
      mem_addr_o <= ADDR_RST;
      mem_wdata_o <= ACC_RST;
      acc_we_o <= 1'b0;
      acc_o <= ACC_RST;
      carry_we_o <= 1'b0;
      carry_o <= 1'b0;
      pc_load_o <= 1'b0;
      pc_o <= PC_RST;
      stack_pop_o <= 1'b0;
      mie_set_o <= 1'b0;
      irq_take_o <= 1'b0;
    end
    else
    begin
      mem_we_o <= next_mem_we;
      mem_addr_o <= next_mem_addr;
      mem_wdata_o <= next_mem_wdata;
      acc_we_o <= next_acc_we;
      acc_o <= next_acc;
      carry_we_o <= next_carry_we;
      carry_o <= next_carry;
      pc_load_o <= next_pc_load;
      pc_o <= next_pc;
      stack_pop_o <= next_pop;
      mie_set_o <= next_mie;
      irq_take_o <= next_irq_take;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  sequence return_issued;
    issue_i && op_i == RIE_OP_RETURN;
  endsequence

  sequence rot_issued(rie_op_t o);
    issue_i && op_i == o;
  endsequence

  return_pc_a: assert property (
    return_issued |=> pc_load_o && mie_set_o && stack_pop_o
      && pc_o == $past(stack_top_i)
      && !carry_we_o && !acc_we_o && !mem_we_o)
    else $error("return did not reload pc and set enable");

  return_irq_a: assert property (
    return_issued |=> irq_take_o == $past(irq_pending_i) && pc_load_o)
    else $error("pending interrupt not taken on return");

  left_mem_a: assert property (
    rot_issued(RIE_OP_ROT_LEFT) |=> mem_we_o && !carry_we_o && !acc_we_o
      && mem_addr_o == $past(addr_i)
      && mem_wdata_o == {$past(mem_rdata_i[MSB-1:LSB]),
                         $past(mem_rdata_i[MSB])})
    else $error("rotate left in place wrong");

  left_acc_a: assert property (
    rot_issued(RIE_OP_ROT_LEFT_ACC) |=> acc_we_o && !mem_we_o
      && !carry_we_o
      && acc_o == {$past(mem_rdata_i[MSB-1:LSB]),
                   $past(mem_rdata_i[MSB])})
    else $error("rotate left to accumulator wrong");

  carry_mem_a: assert property (
    rot_issued(RIE_OP_ROT_LEFT_CARRY) |=> mem_we_o && carry_we_o
      && mem_addr_o == $past(addr_i)
      && carry_o == $past(mem_rdata_i[MSB])
      && mem_wdata_o == {$past(mem_rdata_i[MSB-1:LSB]), $past(carry_i)})
    else $error("rotate left via carry wrong");

  carry_acc_a: assert property (
    rot_issued(RIE_OP_ROT_LEFT_CARRY_ACC) |=> acc_we_o && !mem_we_o
      && carry_we_o
      && carry_o == $past(mem_rdata_i[MSB])
      && acc_o == {$past(mem_rdata_i[MSB-1:LSB]), $past(carry_i)})
    else $error("rotate left via carry to accumulator wrong");

  right_mem_a: assert property (
    rot_issued(RIE_OP_ROT_RIGHT) |=> mem_we_o && !carry_we_o && !acc_we_o
      && mem_addr_o == $past(addr_i)
      && mem_wdata_o == {$past(mem_rdata_i[LSB]),
                         $past(mem_rdata_i[MSB:LSB+1])})
    else $error("rotate right in place wrong");

  right_acc_a: assert property (
    rot_issued(RIE_OP_ROT_RIGHT_ACC) |=> acc_we_o
      ##1 !acc_we_o || $past(issue_i))
    else $error("rotate right to accumulator not delivered");

  right_wrap_a: assert property (
    rot_issued(RIE_OP_ROT_RIGHT_ACC) |=> !mem_we_o && !carry_we_o
      && acc_o == {$past(mem_rdata_i[LSB]),
                   $past(mem_rdata_i[MSB:LSB+1])})
    else $error("rotate right to accumulator wrap wrong");

endmodule : rie_exec

// [rie_pkg.sv]
// Package: opcodes, widths and reset values for the rotate/return unit
package rie_pkg;

  // ------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PC_W = 13;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned MSB = 7;
  localparam int unsigned LSB = 0;

  // ------------------------------------------------------------
  // Operation codes
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    RIE_OP_RETURN = 3'h0,
    RIE_OP_ROT_LEFT = 3'h1,
    RIE_OP_ROT_LEFT_ACC = 3'h2,
    RIE_OP_ROT_LEFT_CARRY = 3'h3,
    RIE_OP_ROT_LEFT_CARRY_ACC = 3'h4,
    RIE_OP_ROT_RIGHT = 3'h5,
    RIE_OP_ROT_RIGHT_ACC = 3'h6
  } rie_op_t;

  // ------------------------------------------------------------
  // Reset values and the MIE value set on return
  // ------------------------------------------------------------
  localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
  localparam logic [PC_W-1:0] PC_RST = 13'h0000;
  localparam logic [ADDR_W-1:0] ADDR_RST = 8'h00;
  localparam logic MIE_SET = 1'b1;

endpackage : rie_pkg

// [rie_rotator.sv]
// Combinational byte rotator shared by all rotate instructions
`timescale 1ns/1ps
module rie_rotator
  import rie_pkg::*;
(
  // Operand
  input wire logic [DATA_W-1:0] data_i,
  input wire logic carry_i,
  // Control
  input wire logic right_i,
  input wire logic via_carry_i,
  // Result
  output logic [DATA_W-1:0] result_o,
  output logic carry_o
);

  always_comb
  begin
    if (right_i)
    begin
      result_o = {data_i[LSB], data_i[MSB:LSB+1]};
      carry_o = data_i[LSB];
    end
    else if (via_carry_i)
    begin
      result_o = {data_i[MSB-1:LSB], carry_i};
      carry_o = data_i[MSB];
    end
    else
    begin
      result_o = {data_i[MSB-1:LSB], data_i[MSB]};
      carry_o = data_i[MSB];
    end
  end

endmodule : rie_rotator

// [rotate_and_interrupt_return_exec_tb_top.sv]
// Self-checking random testbench for the rotate and return unit
`timescale 1ns/1ps
module rotate_and_interrupt_return_exec_tb_top;
  import rie_pkg::*;
  // ------------------------------------------------------------
  // Stimulus and observed signals
  // ------------------------------------------------------------
  logic clock_i, rst_n_i, issue_i, carry_i, irq_pending_i;
  rie_op_t op_i;
  logic [ADDR_W-1:0] addr_i;
  logic [DATA_W-1:0] mem_rdata_i, acc_i;
  logic [PC_W-1:0] stack_top_i;
  logic mem_we_o, acc_we_o, carry_we_o, carry_o, pc_load_o;
  logic stack_pop_o, mie_set_o, irq_take_o;
  logic [ADDR_W-1:0] mem_addr_o;
  logic [DATA_W-1:0] mem_wdata_o, acc_o;
  logic [PC_W-1:0] pc_o;
  logic [15:0] strb;
  logic [31:0] seed, dseed;
  int failures, tests_run, cycles;
  // Inputs as the design sampled them at the last edge
  logic p_rst, p_iss, p_c, p_p;
  logic [2:0] p_op;
  logic [7:0] p_a, p_d;
  logic [12:0] p_s;
  assign strb = {9'h000, mem_we_o, acc_we_o, carry_we_o, pc_load_o,
    stack_pop_o, mie_set_o, irq_take_o};
  rie_exec i_rie_exec (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .issue_i(issue_i), .op_i(op_i), .addr_i(addr_i),
    .mem_rdata_i(mem_rdata_i), .acc_i(acc_i), .carry_i(carry_i),
    .stack_top_i(stack_top_i), .irq_pending_i(irq_pending_i),
    .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o),
    .mem_wdata_o(mem_wdata_o), .acc_we_o(acc_we_o), .acc_o(acc_o),
    .carry_we_o(carry_we_o), .carry_o(carry_o), .pc_load_o(pc_load_o),
    .pc_o(pc_o), .stack_pop_o(stack_pop_o), .mie_set_o(mie_set_o),
    .irq_take_o(irq_take_o));
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  function automatic logic [7:0] rot(input logic [7:0] d, input logic c,
    input logic right, input logic via);
    return right ? {d[0], d[7:1]} : {d[6:0], via ? c : d[7]};
  endfunction : rot
  task automatic close_out;
    if (failures == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out
  task automatic cmp(input logic [15:0] g, input logic [15:0] x);
    tests_run++;
    if (g !== x)
    begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : cmp
  task automatic check;
    if (!p_rst)
    begin
      // Reset clears strobes and every held data output
      cmp(strb, 16'h0000);
      cmp({mem_addr_o, mem_wdata_o}, {ADDR_RST, ACC_RST});
      cmp({acc_o, 7'h00, carry_o}, {ACC_RST, 8'h00});
      cmp(16'(pc_o), 16'(PC_RST));
    end
    else if (!p_iss)
      cmp(strb, 16'h0000);
    else
      case (p_op)
        3'h0:
        begin
          cmp(strb, {9'h000, 6'b000111, p_p});
          cmp(16'(pc_o), 16'(p_s));
        end
        3'h1, 3'h5:
        begin
          cmp(strb, 16'h0040);
          cmp({mem_addr_o, mem_wdata_o},
            {p_a, rot(p_d, p_c, p_op[2], 1'b0)});
        end
        3'h2, 3'h6:
        begin
          cmp(strb, 16'h0020);
          cmp(16'(acc_o), 16'(rot(p_d, p_c, p_op[2], 1'b0)));
        end
        3'h3:
        begin
          cmp(strb, 16'h0050);
          cmp({mem_addr_o, mem_wdata_o}, {p_a, rot(p_d, p_c, 1'b0, 1'b1)});
          cmp(16'(carry_o), 16'(p_d[7]));
        end
        default:
        begin
          cmp(strb, 16'h0030);
          cmp({acc_o, 7'h00, carry_o},
            {rot(p_d, p_c, 1'b0, 1'b1), 7'h00, p_d[7]});
        end
      endcase
  endtask : check
  // ------------------------------------------------------------
  // Clock, capture, check and timeout
  // ------------------------------------------------------------
  initial
  begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  always @(negedge clock_i)
  begin
    {p_rst, p_iss, p_op, p_a, p_d} = {rst_n_i, issue_i, op_i, addr_i,
      mem_rdata_i};
    {p_c, p_s, p_p} = {carry_i, stack_top_i, irq_pending_i};
  end
  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles >= 2000)
    begin
      failures++;
      close_out();
    end
    else
    begin
      #1;
      if (cycles > 1)
        check();
    end
  end
  // ------------------------------------------------------------
  // Main sequence: fixed corner bytes first, then random traffic
  // ------------------------------------------------------------
  initial
  begin
    {issue_i, carry_i, irq_pending_i, addr_i} = '0;
    {mem_rdata_i, acc_i, stack_top_i} = '0;
    op_i = rie_op_t'(3'h0);
    {failures, tests_run, cycles} = '0;
    seed = 32'h4f07;
    dseed = xs(32'h4f07 ^ 32'h1234);
    rst_n_i = 1'b0;
    repeat (10) @(posedge clock_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 600; i++)
    begin
      @(posedge clock_i);
      seed = xs(seed);
      dseed = xs(dseed);
      // Second reset in mid-run, traffic keeps flowing around it
      rst_n_i <= (i < 300) || (i > 302);
      issue_i <= (i < 28) || seed[0] || seed[1];
      op_i <= rie_op_t'(i < 28 ? 3'(i % 7) : 3'(seed[10:8] % 3'h7));
      mem_rdata_i <= i < 14 ? 8'h81 : i < 28 ? 8'h7e : dseed[7:0];
      carry_i <= i < 28 ? i[0] ^ i[3] : dseed[8];
      irq_pending_i <= i < 28 ? i[1] : dseed[9];
      addr_i <= dseed[23:16];
      acc_i <= dseed[31:24];
      stack_top_i <= seed[28:16];
    end
    @(posedge clock_i);
    issue_i <= 1'b0;
    repeat (3) @(posedge clock_i);
    close_out();
  end
endmodule : rotate_and_interrupt_return_exec_tb_top
